/* hw/rlp_defs.svh */
// Constants for the RGB LED PWM register block: offsets, fields, resets, counts.
// Assumes inclusion by bare name from the design module and the testbench.
`ifndef RLP_DEFS_SVH
`define RLP_DEFS_SVH

`define RLP_ADDR_W 12
`define RLP_CTRL_OFS 12'h000
`define RLP_DUTY_OFS 12'h004
`define RLP_BUFA_OFS 12'h100
`define RLP_BUFB_OFS 12'h200
`define RLP_DUTY_NUM 15
`define RLP_SCAN_NUM 12
`define RLP_BUF_BYTES 48
`define RLP_CTRL_RST 8'h00
`define RLP_DUTY_RST 8'h00
`define RLP_CTRL_WMASK 8'hbf
`define RLP_CTRL_RUNMASK 8'h88
`define RLP_BIT_EN 7
`define RLP_BIT_RSV 6
`define RLP_DIV_HI 5
`define RLP_DIV_LO 4
`define RLP_BIT_SEL 3
`define RLP_BIT_POL 2
`define RLP_BIT_CNT 1
`define RLP_BIT_SCAN 0
`define RLP_DIV3_CODE 2'h2
`define RLP_PERIOD_LAST 8'hff
`define RLP_LOAD_SUB_LAST 2'h3
`define RLP_LOAD_IDX_LAST 4'hb
`define RLP_PHASE_LAST3 2'h2
`define RLP_PHASE_LAST4 2'h3
`define RLP_RESP_OKAY 2'h0
`define RLP_RESP_SLVERR 2'h2
`define RLP_RESP_DECERR 2'h3

`endif

/* hw/rlp_pkg.sv */
// Types shared by the RGB LED PWM register block.
// Assumes rlp_defs.svh is on the include path.
package rlp_pkg;
    typedef enum {RLP_K_NONE, RLP_K_CTRL, RLP_K_DUTY, RLP_K_BUFA, RLP_K_BUFB} rlp_kind_e;
    typedef enum {RLP_IDLE, RLP_LOAD, RLP_SHOW} rlp_state_e;
    typedef struct packed {
        rlp_kind_e kind;
        logic [5:0] idx;
    } rlp_dec_s;
endpackage

/* hw/rlp_pwm_regs.sv */
// RGB LED PWM unit: control and duty registers, scan buffers, divider and waveform logic.
// Assumes an AXI4-Lite master on the same clock; LED pins are driven from flip-flops.
//
// Summary of operation
// R1: Control bit 7 enables all PWM outputs.
// R2: While enabled, only buffer-select and enable change.
// R3: Disabled: commons inactive, colours 0-11 high.
// R4: Divider field bits 5:4 divide by 1-4.
// R5: Divide-by-three clock: two high, one low.
// R6: Bit 3 picks scan buffer A or B.
// R7: Buffer select sampled only at frame end.
// R8: Scanning blocks software access to scanned buffer.
// R9: Bit 2 sets common active level.
// R10: Direct mode holds commons inactive.
// R11: Disabled commons sit at inverse of polarity.
// R12: Software sets polarity before enabling.
// R13: Bit 1 selects three or four commons.
// R14: Bit 0 selects direct or scanning mode.
// R15: Bit 6 reads zero; others reset zero.
// R16: Fifteen duty registers, reset zero, LED triples.
// R17: Scanning makes LED 0-3 duty read-only.
// R18: LED 4 duty unused while scanning.
// R19: 256-clock period; duty changes at boundary.
// R20: Scanning loads twelve bytes per common phase.
// R21: Active time equals duty; zero gives none.
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "rlp_defs.svh"

module rlp_pwm_regs (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`RLP_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [`RLP_ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic [`RLP_DUTY_NUM-1:0] colourChannelOutputs,
    output logic [3:0] commonLineOutputs,
    output logic dividedPwmClock
);
    import rlp_pkg::*;

    // ---------------------------------------------------------------
    // Decode helpers
    // ---------------------------------------------------------------
    function automatic rlp_dec_s decodeAddr(input logic [`RLP_ADDR_W-1:0] a);
        rlp_dec_s d;
        logic [`RLP_ADDR_W-1:0] off;
        d.kind = RLP_K_NONE;
        d.idx = 6'h00;
        off = 12'h000;
        if (a[1:0] == 2'h0) begin
            if (a == `RLP_CTRL_OFS) begin
                d.kind = RLP_K_CTRL;
            end else if (a >= `RLP_DUTY_OFS && a < `RLP_BUFA_OFS) begin
                off = a - `RLP_DUTY_OFS;
                if (off[11:2] < `RLP_DUTY_NUM) begin
                    d.kind = RLP_K_DUTY;
                    d.idx = off[7:2];
                end
            end else if (a >= `RLP_BUFA_OFS && a < `RLP_BUFB_OFS) begin
                off = a - `RLP_BUFA_OFS;
                if (off[11:2] < `RLP_BUF_BYTES) begin
                    d.kind = RLP_K_BUFA;
                    d.idx = off[7:2];
                end
            end else if (a >= `RLP_BUFB_OFS) begin
                off = a - `RLP_BUFB_OFS;
                if (off[11:2] < `RLP_BUF_BYTES) begin
                    d.kind = RLP_K_BUFB;
                    d.idx = off[7:2];
                end
            end
        end
        return d;
    endfunction

    // Refusals answer SLVERR so software learns the access had no effect.
    function automatic logic [1:0] accessResp(input rlp_dec_s d, input logic wr,
                                              input logic scan, input logic sel);
        logic [1:0] r;
        r = `RLP_RESP_OKAY;
        case (d.kind)
            RLP_K_NONE: r = `RLP_RESP_DECERR;
            RLP_K_BUFA: if (scan && !sel) r = `RLP_RESP_SLVERR; // R8
            RLP_K_BUFB: if (scan && sel) r = `RLP_RESP_SLVERR; // R8
            RLP_K_DUTY: if (scan && (wr || d.idx >= `RLP_SCAN_NUM)) r = `RLP_RESP_SLVERR; // R17 R18
            default: r = `RLP_RESP_OKAY;
        endcase
        return r;
    endfunction

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic [7:0] ctrl_r;
    logic [14:0][7:0] duty_r;
    logic [14:0][7:0] dutyEff_r;
    logic [7:0] bufA [0:`RLP_BUF_BYTES-1];
    logic [7:0] bufB [0:`RLP_BUF_BYTES-1];
    logic awHave_r, wHave_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [`RLP_ADDR_W-1:0] awAddr_r;
    logic [7:0] wData_r;
    logic wStrb0_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    rlp_state_e state_r;
    logic [7:0] cnt_r;
    logic [1:0] phase_r, divCnt_r, loadSub_r;
    logic [3:0] loadIdx_r;
    logic scanSel_r, divided_pwm_clock_r;
    logic [`RLP_DUTY_NUM-1:0] colour_r;
    logic [3:0] common_r;

    logic en, scan, pol, tick, doWrite, wEn, loadByte, periodEnd, frameEnd;
    logic [1:0] lastPhase, wResp, hiCount;
    logic [5:0] bufAddr;
    logic [7:0] scanByte, rdByte;
    rlp_dec_s wDec, rDec;

    assign en = ctrl_r[`RLP_BIT_EN];
    assign scan = ctrl_r[`RLP_BIT_SCAN];
    assign pol = ctrl_r[`RLP_BIT_POL];
    assign lastPhase = ctrl_r[`RLP_BIT_CNT] ? `RLP_PHASE_LAST4 : `RLP_PHASE_LAST3; // R13
    assign tick = en && (divCnt_r == ctrl_r[`RLP_DIV_HI:`RLP_DIV_LO]); // R4
    assign hiCount = 2'((3'(ctrl_r[`RLP_DIV_HI:`RLP_DIV_LO]) + 3'h2) >> 1); // R5
    assign wDec = decodeAddr(awAddr_r);
    assign rDec = decodeAddr(s_axi_araddr);
    assign wResp = accessResp(wDec, 1'b1, scan, scanSel_r);
    assign doWrite = awHave_r && wHave_r && !bvalid_r;
    assign wEn = doWrite && wStrb0_r && (wResp == `RLP_RESP_OKAY);
    assign bufAddr = 6'(phase_r) * 6'h0c + 6'(loadIdx_r); // R20
    assign scanByte = scanSel_r ? bufB[bufAddr] : bufA[bufAddr]; // R6
    assign loadByte = en && state_r == RLP_LOAD && tick && loadSub_r == `RLP_LOAD_SUB_LAST;
    assign periodEnd = en && state_r == RLP_SHOW && tick && cnt_r == `RLP_PERIOD_LAST;
    assign frameEnd = periodEnd && scan && phase_r == lastPhase;

    // ---------------------------------------------------------------
    // Control and duty registers
    // ---------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= `RLP_CTRL_RST; // R15
        end else if (wEn && wDec.kind == RLP_K_CTRL) begin
            if (en) begin
                ctrl_r <= (ctrl_r & ~`RLP_CTRL_RUNMASK) | (wData_r & `RLP_CTRL_RUNMASK); // R2
            end else begin
                ctrl_r <= wData_r & `RLP_CTRL_WMASK; // R15
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            duty_r <= {`RLP_DUTY_NUM{`RLP_DUTY_RST}}; // R16
        end else begin
            if (wEn && wDec.kind == RLP_K_DUTY) begin
                duty_r[wDec.idx[3:0]] <= wData_r; // R16
            end
            if (loadByte) begin
                duty_r[loadIdx_r] <= scanByte; // R20
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < `RLP_BUF_BYTES; i++) begin
                bufA[i] <= 8'h00;
                bufB[i] <= 8'h00;
            end
        end else if (wEn && wDec.kind == RLP_K_BUFA) begin
            bufA[wDec.idx] <= wData_r;
        end else if (wEn && wDec.kind == RLP_K_BUFB) begin
            bufB[wDec.idx] <= wData_r;
        end
    end

    // ---------------------------------------------------------------
    // AXI4-Lite write channel
    // ---------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `RLP_RESP_OKAY;
            awAddr_r <= 12'h000;
            wData_r <= 8'h00;
            wStrb0_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && awready_r) begin
                awAddr_r <= s_axi_awaddr;
                awHave_r <= 1'b1;
                awready_r <= 1'b0;
            end
            if (s_axi_wvalid && wready_r) begin
                wData_r <= s_axi_wdata[7:0];
                wStrb0_r <= s_axi_wstrb[0];
                wHave_r <= 1'b1;
                wready_r <= 1'b0;
            end
            if (doWrite) begin
                bvalid_r <= 1'b1;
                bresp_r <= wResp;
                awHave_r <= 1'b0;
                wHave_r <= 1'b0;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // AXI4-Lite read channel
    // ---------------------------------------------------------------
    always_comb begin
        case (rDec.kind)
            RLP_K_CTRL: rdByte = ctrl_r & `RLP_CTRL_WMASK; // R15
            RLP_K_DUTY: rdByte = duty_r[rDec.idx[3:0]];
            RLP_K_BUFA: rdByte = bufA[rDec.idx];
            RLP_K_BUFB: rdByte = bufB[rDec.idx];
            default: rdByte = 8'h00;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= `RLP_RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= accessResp(rDec, 1'b0, scan, scanSel_r); // R8
            if (accessResp(rDec, 1'b0, scan, scanSel_r) == `RLP_RESP_OKAY) begin
                rdata_r <= {24'h00_0000, rdByte};
            end else begin
                rdata_r <= 32'h0000_0000;
            end
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Clock divider
    // ---------------------------------------------------------------
    // A divide-by-one clock cannot be shown as a level, so it reads as a constant high.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            divCnt_r <= 2'h0;
            divided_pwm_clock_r <= 1'b0;
        end else begin
            divCnt_r <= (!en || tick) ? 2'h0 : divCnt_r + 2'h1; // R4
            divided_pwm_clock_r <= en && (divCnt_r < hiCount); // R5
        end
    end

    // ---------------------------------------------------------------
    // Period counter and scan sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= RLP_IDLE;
            cnt_r <= 8'h00;
            phase_r <= 2'h0;
            loadSub_r <= 2'h0;
            loadIdx_r <= 4'h0;
            scanSel_r <= 1'b0;
        end else if (!en) begin
            state_r <= RLP_IDLE; // R1
            cnt_r <= 8'h00;
            phase_r <= 2'h0;
            loadSub_r <= 2'h0;
            loadIdx_r <= 4'h0;
            scanSel_r <= ctrl_r[`RLP_BIT_SEL];
        end else begin
            case (state_r)
                RLP_IDLE: begin
                    state_r <= scan ? RLP_LOAD : RLP_SHOW; // R14
                    cnt_r <= 8'h00;
                end
                RLP_LOAD: begin
                    if (tick) begin
                        loadSub_r <= loadSub_r + 2'h1;
                        if (loadSub_r == `RLP_LOAD_SUB_LAST) begin
                            if (loadIdx_r == `RLP_LOAD_IDX_LAST) begin
                                loadIdx_r <= 4'h0;
                                state_r <= RLP_SHOW;
                                cnt_r <= 8'h00;
                            end else begin
                                loadIdx_r <= loadIdx_r + 4'h1; // R20
                            end
                        end
                    end
                end
                RLP_SHOW: begin
                    if (tick) begin
                        cnt_r <= cnt_r + 8'h01; // R19
                    end
                    if (periodEnd && scan) begin
                        state_r <= RLP_LOAD;
                        if (frameEnd) begin
                            phase_r <= 2'h0;
                            scanSel_r <= ctrl_r[`RLP_BIT_SEL]; // R7
                        end else begin
                            phase_r <= phase_r + 2'h1; // R13
                        end
                    end
                end
                default: state_r <= RLP_IDLE;
            endcase
        end
    end

    // Direct mode keeps the running count; new duties wait for the period boundary.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            dutyEff_r <= {`RLP_DUTY_NUM{`RLP_DUTY_RST}};
        end else if (state_r == RLP_IDLE || periodEnd) begin
            dutyEff_r <= duty_r; // R19
        end
    end

    // ---------------------------------------------------------------
    // Output stage
    // ---------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            colour_r <= {`RLP_DUTY_NUM{1'b1}};
            common_r <= 4'hf;
        end else begin
            for (int i = 0; i < `RLP_DUTY_NUM; i++) begin
                colour_r[i] <= !(en && state_r == RLP_SHOW && !(scan && i >= `RLP_SCAN_NUM)
                    && cnt_r < (scan ? duty_r[i] : dutyEff_r[i])); // R3 R18 R21
            end
            for (int m = 0; m < 4; m++) begin
                common_r[m] <= (en && scan && state_r == RLP_SHOW && phase_r == 2'(m))
                    ? pol : !pol; // R9 R10 R11
            end
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign colourChannelOutputs = colour_r;
    assign commonLineOutputs = common_r;
    assign dividedPwmClock = divided_pwm_clock_r;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_div3High;
        (en && ctrl_r[5:4] == `RLP_DIV3_CODE && $rose(divided_pwm_clock_r)) ##1
        (en && ctrl_r[5:4] == `RLP_DIV3_CODE);
    endsequence
    sequence s_div3Tail;
        divided_pwm_clock_r ##1 !divided_pwm_clock_r;
    endsequence
    property p_div3Shape;
        s_div3High |-> s_div3Tail;
    endproperty
    a_div3Shape: assert property (p_div3Shape) else $error("div3 shape wrong"); // R5

    property p_offColour;
        !en |=> colour_r[11:0] == 12'hfff;
    endproperty
    a_offColour: assert property (p_offColour) else $error("colour not high"); // R3

    property p_offCommon;
        !en |=> common_r == {4{!$past(pol)}};
    endproperty
    a_offCommon: assert property (p_offCommon) else $error("common not inactive"); // R11

    property p_directCommon;
        en && !scan |=> common_r == {4{!pol}};
    endproperty
    a_directCommon: assert property (p_directCommon) else $error("direct common"); // R10

    property p_lockedFields;
        en |=> (ctrl_r & 8'h37) == ($past(ctrl_r) & 8'h37);
    endproperty
    a_lockedFields: assert property (p_lockedFields) else $error("locked field moved"); // R2

    property p_bit6Zero;
        s_axi_arvalid && arready_r && s_axi_araddr == `RLP_CTRL_OFS |=> !rdata_r[6];
    endproperty
    a_bit6Zero: assert property (p_bit6Zero) else $error("bit 6 read as one"); // R15

    property p_scanReadOnly;
        en && scan && state_r == RLP_SHOW |=> duty_r[11:0] == $past(duty_r[11:0]);
    endproperty
    a_scanReadOnly: assert property (p_scanReadOnly) else $error("duty changed"); // R17

    property p_selAtFrameEnd;
        en && !$stable(scanSel_r) |-> $past(frameEnd);
    endproperty
    a_selAtFrameEnd: assert property (p_selAtFrameEnd) else $error("select early"); // R7

    property p_bufBlocked;
        s_axi_arvalid && arready_r && scan && rDec.kind == RLP_K_BUFA && !scanSel_r
        |=> rresp_r == `RLP_RESP_SLVERR;
    endproperty
    a_bufBlocked: assert property (p_bufBlocked) else $error("buffer not blocked"); // R8

    property p_zeroDuty;
        en && !scan && dutyEff_r[0] == 8'h00 |=> colour_r[0];
    endproperty
    a_zeroDuty: assert property (p_zeroDuty) else $error("zero duty active"); // R21

    property p_phaseLimit;
        !ctrl_r[`RLP_BIT_CNT] |-> phase_r != 2'h3;
    endproperty
    a_phaseLimit: assert property (p_phaseLimit) else $error("fourth phase used"); // R13
endmodule

/* verification/rlp_led_load.sv */
// LED load model: watches colour channel 0, the common lines and the divided clock of the PWM unit.
// Assumes the bench gives the common active level and pulses clearCounts between windows.
`timescale 1ns/1ps

module rlp_led_load (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [14:0] colourChannelOutputs,
    input wire logic [3:0] commonLineOutputs,
    input wire logic dividedPwmClock,
    input wire logic activeHigh,
    input wire logic clearCounts,
    output logic [31:0] litCount,
    output logic [31:0] highCount,
    output logic [3:0] commonSeen
);
    // ----------------------------------------------------------------
    // Load behaviour
    // ----------------------------------------------------------------
    // A channel lights while driven low, so counting low cycles measures duty in system clocks.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            litCount <= 32'h0;
            highCount <= 32'h0;
            commonSeen <= 4'h0;
        end else if (clearCounts) begin
            litCount <= 32'h0;
            highCount <= 32'h0;
            commonSeen <= 4'h0;
        end else begin
            litCount <= litCount + {31'h0, ~colourChannelOutputs[0]};
            highCount <= highCount + {31'h0, dividedPwmClock};
            commonSeen <= commonSeen | (activeHigh ? commonLineOutputs : ~commonLineOutputs);
        end
    end
endmodule

/* verification/tb.sv */
// Self-checking bench for the RGB LED PWM register block over AXI4-Lite.
// Assumes rlp_defs.svh on the include path and the LED load model beside the design.
`timescale 1ns/1ps
`include "rlp_defs.svh"

module tb;
    import rlp_pkg::*;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    localparam logic [1:0] OK = `RLP_RESP_OKAY;
    localparam logic [1:0] SLV = `RLP_RESP_SLVERR;
    localparam logic [1:0] DEC = `RLP_RESP_DECERR;
    localparam logic [11:0] CTRL = `RLP_CTRL_OFS;
    localparam logic [11:0] DUTY = `RLP_DUTY_OFS;
    localparam logic [11:0] BUFA = `RLP_BUFA_OFS;
    localparam logic [11:0] BUFB = `RLP_BUFB_OFS;
    logic clock, sys_rst, awValid, awReady, wValid, wReady, bValid, bReady;
    logic arValid, arReady, rValid, rReady, divided_pwm_clock, activeHigh, clearCounts;
    logic [11:0] awAddr, arAddr;
    logic [31:0] wData, rData, litCount, highCount;
    logic [3:0] wStrb, commons, commonSeen;
    logic [1:0] bResp, rResp;
    logic [14:0] colours;
    int n_fail, check_count;

    rlp_pwm_regs rlp_pwm_regs_i (.clock(clock), .sys_rst(sys_rst),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_awaddr(awAddr),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData),
        .s_axi_wstrb(wStrb), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_bresp(bResp), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_araddr(arAddr), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .colourChannelOutputs(colours),
        .commonLineOutputs(commons), .dividedPwmClock(divided_pwm_clock));
    rlp_led_load rlp_led_load_i (.clock(clock), .sys_rst(sys_rst),
        .colourChannelOutputs(colours), .commonLineOutputs(commons),
        .dividedPwmClock(divided_pwm_clock), .activeHigh(activeHigh), .clearCounts(clearCounts),
        .litCount(litCount), .highCount(highCount), .commonSeen(commonSeen));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            n_fail++;
        end
    endtask

    // Address and data are offered together; each is dropped at its own handshake edge.
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        logic awDone;
        logic wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge clock);
        awAddr <= a;
        wData <= {24'h0, d};
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge clock);
            if (!awDone && awReady) begin
                awDone = 1'b1;
                awValid <= 1'b0;
            end
            if (!wDone && wReady) begin
                wDone = 1'b1;
                wValid <= 1'b0;
            end
        end
        do @(posedge clock); while (bValid !== 1'b1);
        bReady <= 1'b0;
        check("bresp", {30'h0, bResp}, {30'h0, er});
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] ed, input logic [1:0] er);
        @(posedge clock);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do @(posedge clock); while (arReady !== 1'b1);
        arValid <= 1'b0;
        do @(posedge clock); while (rValid !== 1'b1);
        rReady <= 1'b0;
        check("rresp", {30'h0, rResp}, {30'h0, er});
        check("rdata", rData, {24'h0, ed});
    endtask

    task automatic clr();
        clearCounts <= 1'b1;
        @(posedge clock);
        clearCounts <= 1'b0;
    endtask

    task automatic conclude();
        if (n_fail == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge clock);
        n_fail++;
        conclude();
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        {awValid, wValid, bReady, arValid, rReady, activeHigh, clearCounts} = 7'h0;
        awAddr = 12'h0;
        arAddr = 12'h0;
        wData = 32'h0;
        wStrb = 4'h1;
        n_fail = 0;
        check_count = 0;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        check("colours", {17'h0, colours}, 32'h7fff);
        check("commons", {28'h0, commons}, 32'hf);
        rd(CTRL, 8'h00, OK);
        for (int i = 0; i < 15; i++) rd(DUTY + 12'(4 * i), 8'h00, OK);
        for (int i = 0; i < 15; i++) wr(DUTY + 12'(4 * i), 8'(8'h40 + i), OK);
        for (int i = 0; i < 15; i++) rd(DUTY + 12'(4 * i), 8'(8'h40 + i), OK);
        // A write with its low strobe clear is answered but must leave the byte alone.
        wStrb <= 4'h0;
        wr(DUTY + 12'h004, 8'hee, OK);
        wStrb <= 4'h1;
        rd(DUTY + 12'h004, 8'h41, OK);
        wr(CTRL, 8'h40, OK);
        rd(CTRL, 8'h00, OK);
        wr(CTRL, 8'h3e, OK);
        rd(CTRL, 8'h3e, OK);
        rd(12'h800, 8'h00, DEC);
        // Each divider code gets two settling periods, then one period measured exactly.
        for (int c = 0; c < 4; c++) begin
            wr(CTRL, {2'b00, 2'(c), 4'h0}, OK);
            wr(CTRL, {2'b10, 2'(c), 4'h0}, OK);
            repeat (512 * (c + 1)) @(posedge clock);
            clr();
            repeat (256 * (c + 1) + 1) @(posedge clock);
            check("lit", litCount, 32'(64 * (c + 1)));
            if (c == 0) check("divided_pwm_clock", highCount, 32'd256);
            if (c == 1) check("divided_pwm_clock", highCount, 32'd256);
            if (c == 2) check("divided_pwm_clock", highCount, 32'd512);
            if (c == 3) check("divided_pwm_clock", highCount, 32'd512);
            check("commons", {28'h0, commons}, 32'hf);
        end
        wr(CTRL, 8'h80, OK);
        rd(CTRL, 8'hb0, OK);
        wr(CTRL, 8'hb8, OK);
        rd(CTRL, 8'hb8, OK);
        wr(CTRL, 8'h30, OK);
        clr();
        repeat (1100) @(posedge clock);
        check("lit", litCount, 32'h0);
        check("colours", {20'h0, colours[11:0]}, 32'hfff);
        check("commons", {28'h0, commons}, 32'hf);
        wr(DUTY, 8'h00, OK);
        wr(CTRL, 8'hb0, OK);
        repeat (2100) @(posedge clock);
        clr();
        repeat (1025) @(posedge clock);
        check("lit", litCount, 32'h0);
        for (int i = 0; i < 4; i++) wr(BUFA + 12'(48 * i), 8'h5a, OK);
        // The unit still runs here, so the first write only clears the enable.
        wr(CTRL, 8'h00, OK);
        rd(CTRL, 8'h30, OK);
        // Polarity goes in while disabled, before the enable, so commons never glitch active.
        wr(CTRL, 8'h05, OK);
        activeHigh <= 1'b1;
        repeat (3) @(posedge clock);
        check("commons", {28'h0, commons}, 32'h0);
        wr(CTRL, 8'h85, OK);
        wr(DUTY, 8'h11, SLV);
        rd(DUTY + 12'd48, 8'h00, SLV);
        rd(BUFA, 8'h00, SLV);
        wr(BUFB, 8'h33, OK);
        clr();
        repeat (2000) @(posedge clock);
        check("seen", {28'h0, commonSeen}, 32'h7);
        rd(DUTY, 8'h5a, OK);
        check("colours", {29'h0, colours[14:12]}, 32'h7);
        wr(CTRL, 8'h8d, OK);
        repeat (2000) @(posedge clock);
        rd(BUFB, 8'h00, SLV);
        rd(BUFA, 8'h5a, OK);
        wr(CTRL, 8'h0f, OK);
        rd(CTRL, 8'h0d, OK);
        wr(CTRL, 8'h0f, OK);
        wr(CTRL, 8'h8f, OK);
        clr();
        repeat (2600) @(posedge clock);
        check("seen", {28'h0, commonSeen}, 32'hf);
        // Same scan with active-low commons: every line must still be driven active.
        wr(CTRL, 8'h0f, OK);
        wr(CTRL, 8'h0b, OK);
        rd(CTRL, 8'h0b, OK);
        activeHigh <= 1'b0;
        wr(CTRL, 8'h8b, OK);
        clr();
        repeat (2600) @(posedge clock);
        check("seen", {28'h0, commonSeen}, 32'hf);
        conclude();
    end
endmodule
